// ### hdl/usr_top.sv
// universal eight-bit shift and storage register with shared parallel pins
`timescale 1ns/1ps
module usr_top (
  input  wire logic                      i_clock,
  input  wire logic                      i_rst_n,
  input  wire logic                      i_shift_clock,
  input  wire logic                      i_master_clear_n,
  input  wire logic                      i_mode_sel_lo,
  input  wire logic                      i_mode_sel_hi,
  input  wire logic                      i_serial_in_right,
  input  wire logic                      i_serial_in_left,
  input  wire logic                      i_out_en_n_a,
  input  wire logic                      i_out_en_n_b,
  input  wire logic [usr_pkg::WIDTH-1:0] i_shared_parallel_pins,
  output logic      [usr_pkg::WIDTH-1:0] o_shared_parallel_pins,
  output logic      [usr_pkg::WIDTH-1:0] o_shared_parallel_pins_oe,
  output logic                           o_serial_out_first,
  output logic                           o_serial_out_last,
  output logic                           o_snap_valid,
  output logic      [usr_pkg::WIDTH-1:0] o_snap_data,
  input  wire logic                      i_snap_ready,
  output logic                           o_snap_lost
);

  // reset release through two flops
  logic rst1_q;
  logic rst2_q;
  wire  rst_n = rst2_q;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst1_q <= 1'b0;
      rst2_q <= 1'b0;
    end else begin
      rst1_q <= 1'b1;
      rst2_q <= rst1_q;
    end
  end

  // clear asserts at once, releases through two flops
  // reset joins it so both clear the stored bits
  wire  clr_src_n = i_rst_n & i_master_clear_n;
  logic clr1_q;
  logic clr2_q;
  wire  state_rst_n = clr2_q;

  always_ff @(posedge i_clock or negedge clr_src_n) begin
    if (!clr_src_n) begin
      clr1_q <= 1'b0;
      clr2_q <= 1'b0;
    end else begin
      clr1_q <= 1'b1;
      clr2_q <= clr1_q;
    end
  end

  // pin input synchronisers
  // reset to idle levels so the pins stay released
  logic [usr_pkg::SYNC_BITS-1:0] sync1_q;
  logic [usr_pkg::SYNC_BITS-1:0] sync2_q;
  wire  [usr_pkg::SYNC_BITS-1:0] pins_raw = {
    i_shift_clock,
    i_mode_sel_hi,
    i_mode_sel_lo,
    i_serial_in_right,
    i_serial_in_left,
    i_out_en_n_a,
    i_out_en_n_b,
    i_shared_parallel_pins
  };

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= usr_pkg::SYNC_IDLE;
      sync2_q <= usr_pkg::SYNC_IDLE;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
    end
  end

  wire                      s_shift_clock = sync2_q[usr_pkg::POS_SHIFT_CLOCK];
  wire                      s_sel_hi      = sync2_q[usr_pkg::POS_SEL_HI];
  wire                      s_sel_lo      = sync2_q[usr_pkg::POS_SEL_LO];
  wire                      s_ser_right   = sync2_q[usr_pkg::POS_SER_RIGHT];
  wire                      s_ser_left    = sync2_q[usr_pkg::POS_SER_LEFT];
  wire                      s_oe_n_a      = sync2_q[usr_pkg::POS_OE_N_A];
  wire                      s_oe_n_b      = sync2_q[usr_pkg::POS_OE_N_B];
  wire [usr_pkg::WIDTH-1:0] s_par_pins    = sync2_q[usr_pkg::WIDTH-1:0];

  // rising edge of the shift clock
  // previous level resets low, the idle pin level
  logic clk_prev_q;
  wire  shift_edge = s_shift_clock && !clk_prev_q;

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      clk_prev_q <= 1'b0;
    end else begin
      clk_prev_q <= s_shift_clock;
    end
  end

  // mode decode and next-state selection
  usr_pkg::usr_mode_t mode;
  assign mode = usr_pkg::decode_mode(s_sel_hi, s_sel_lo);

  logic [usr_pkg::WIDTH-1:0] state_q;
  logic [usr_pkg::WIDTH-1:0] state_d;

  wire [usr_pkg::WIDTH-1:0] shifted_right = {state_q[usr_pkg::MSB-1:0], s_ser_right};
  wire [usr_pkg::WIDTH-1:0] shifted_left  = {s_ser_left, state_q[usr_pkg::MSB:1]};

  always_comb begin
    unique case (mode)
      usr_pkg::MODE_HOLD:  state_d = state_q;        // R7
      usr_pkg::MODE_RIGHT: state_d = shifted_right;  // R5
      usr_pkg::MODE_LEFT:  state_d = shifted_left;   // R6
      usr_pkg::MODE_LOAD:  state_d = s_par_pins;     // R4
    endcase
  end

  // eight stored bits, cleared asynchronously
  // selects and data are the synced copies
  always_ff @(posedge i_clock or negedge state_rst_n) begin
    if (!state_rst_n) begin
      state_q <= usr_pkg::CLEAR_VALUE;  // R3
    end else if (shift_edge) begin
      state_q <= state_d;  // R1 R2 R9
    end
  end

  // pin drivers and serial outputs
  wire load_sel     = (mode == usr_pkg::MODE_LOAD);  // R10
  wire enables_low  = !s_oe_n_a && !s_oe_n_b;        // R8
  wire pins_enabled = enables_low && !load_sel;      // R8 R10
  wire [usr_pkg::WIDTH-1:0] oe_d = pins_enabled ? usr_pkg::PINS_DRIVEN : usr_pkg::PINS_FLOAT;

  logic [usr_pkg::WIDTH-1:0] oe_q;

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      oe_q <= usr_pkg::PINS_FLOAT;
    end else begin
      oe_q <= oe_d;  // R8 R10
    end
  end

  assign o_shared_parallel_pins    = state_q;  // R8
  assign o_shared_parallel_pins_oe = oe_q;

  // end bits for chaining
  assign o_serial_out_first        = state_q[0];            // R12
  assign o_serial_out_last         = state_q[usr_pkg::MSB]; // R12

  // snapshot of every word changed on a shift edge, held until the fifo accepts it or the next change overwrites it
  // an edge during clear stores nothing, so nothing is captured
  wire  edge_taken = shift_edge && state_rst_n;
  wire  changed    = edge_taken && (state_d != state_q);
  logic                      pend_valid_q;
  logic [usr_pkg::WIDTH-1:0] pend_data_q;
  logic                      lost_q;
  logic                      fifo_in_ready;
  logic                      fifo_out_valid;
  logic [usr_pkg::WIDTH-1:0] fifo_out_data;
  logic                      out_valid_q;
  logic [usr_pkg::WIDTH-1:0] out_data_q;

  // stream stalls back into the pending word
  wire fifo_out_ready = !out_valid_q || i_snap_ready;
  wire overwrite      = changed && pend_valid_q && !fifo_in_ready;

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      pend_valid_q <= 1'b0;
      pend_data_q  <= usr_pkg::CLEAR_VALUE;
      lost_q       <= 1'b0;
    end else begin
      if (changed) begin
        pend_valid_q <= 1'b1;
        pend_data_q  <= state_d;
      end else if (fifo_in_ready) begin
        pend_valid_q <= 1'b0;
      end
      if (overwrite) begin
        lost_q <= 1'b1;
      end
    end
  end

  // eight-word buffer between capture and stream
  usr_fifo #(
    .W (usr_pkg::WIDTH),
    .D (usr_pkg::FIFO_DEPTH)
  ) usr_fifo_inst (
    .i_clock     (i_clock),
    .i_rst_n     (rst_n),
    .i_in_valid  (pend_valid_q),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (pend_data_q),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (fifo_out_ready),
    .o_out_data  (fifo_out_data)
  );

  // registered stream output
  // advances when empty or when the word is taken
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      out_valid_q <= 1'b0;
      out_data_q  <= usr_pkg::CLEAR_VALUE;
    end else if (fifo_out_ready) begin
      out_valid_q <= fifo_out_valid;
      out_data_q  <= fifo_out_data;
    end
  end

  assign o_snap_valid = out_valid_q;
  assign o_snap_data  = out_data_q;
  assign o_snap_lost  = lost_q;

endmodule

// ### hdl/usr_pkg.sv
// constants, mode enumeration and shared helpers for the universal shift register
// Function
// R1: eight stored bits, one edge-triggered flip-flop per position zero to seven.
// R2: stored bits change only on a rising shift clock edge, except clear.
// R3: active-low master clear forces all bits low at once, over mode and clock.
// R4: both mode selects high: rising edge copies each parallel pin into its bit.
// R5: select one low, zero high: right-shift input to bit zero, bit n to n+1.
// R6: select one high, zero low: left-shift input to bit seven, bit n to n-1.
// R7: both mode selects low: stored bits hold whatever the clock does.
// R8: each bit drives its parallel pin; pins float while either enable is high.
// R9: with pins floated, shift, hold, load and clear still work as selected.
// R10: pins also float while both mode selects are high, whatever the enables.
// R11: outside logic drives the parallel pins with the new word during load.
// R12: bit zero and bit seven always shown on their own serial output pins.
package usr_pkg;

  localparam int unsigned WIDTH      = 8;
  localparam int unsigned MSB        = 7;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned SYNC_BITS  = 15;

  // bit positions inside the pin synchroniser word
  localparam int unsigned POS_SHIFT_CLOCK = 14;
  localparam int unsigned POS_SEL_HI      = 13;
  localparam int unsigned POS_SEL_LO      = 12;
  localparam int unsigned POS_SER_RIGHT   = 11;
  localparam int unsigned POS_SER_LEFT    = 10;
  localparam int unsigned POS_OE_N_A      = 9;
  localparam int unsigned POS_OE_N_B      = 8;

  // synchroniser reset: both enables high, all else low
  localparam logic [SYNC_BITS-1:0] SYNC_IDLE = 15'h0300;

  localparam logic [WIDTH-1:0] CLEAR_VALUE = 8'h00;
  localparam logic [WIDTH-1:0] PINS_DRIVEN = 8'hff;
  localparam logic [WIDTH-1:0] PINS_FLOAT  = 8'h00;

  typedef enum logic [1:0] {
    MODE_HOLD,
    MODE_RIGHT,
    MODE_LEFT,
    MODE_LOAD
  } usr_mode_t;

  // selects to operating mode
  function automatic usr_mode_t decode_mode(input logic sel_hi, input logic sel_lo);
    usr_mode_t m;
    m = MODE_HOLD;
    if (sel_hi && sel_lo) begin
      m = MODE_LOAD;
    end else if (sel_lo) begin
      m = MODE_RIGHT;
    end else if (sel_hi) begin
      m = MODE_LEFT;
    end
    return m;
  endfunction

endpackage

// ### hdl/usr_fifo.sv
// parameterised flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ps
module usr_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned D = 8
) (
  input  wire logic         i_clock,
  input  wire logic         i_rst_n,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);

  localparam int unsigned AW = (D > 1) ? $clog2(D) : 1;
  localparam logic [AW:0] FULL_COUNT = AW'(D) == '0 ? (AW+1)'(D) : (AW+1)'(D);
  localparam logic [AW-1:0] LAST_IDX = AW'(D - 1);

  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   count_q;

  wire push = i_in_valid && o_in_ready;
  wire pop  = o_out_valid && i_out_ready;

  assign o_in_ready  = (count_q != FULL_COUNT);
  assign o_out_valid = (count_q != '0);
  assign o_out_data  = mem_q[rd_q];

  // index step with wrap
  function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
    return (p == LAST_IDX) ? '0 : p + 1'b1;
  endfunction

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_q    <= '0;
      rd_q    <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_q <= step(wr_q);
      end
      if (pop) begin
        rd_q <= step(rd_q);
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (push) begin
      mem_q[wr_q] <= i_in_data;
    end
  end

endmodule

// ### tb/usr_asserts.sv
// concurrent checks on the shift register top ports
`timescale 1ns/1ps
module usr_asserts (
  input wire logic       i_clock,
  input wire logic       i_rst_n,
  input wire logic       i_shift_clock,
  input wire logic       i_master_clear_n,
  input wire logic       i_mode_sel_lo,
  input wire logic       i_mode_sel_hi,
  input wire logic       i_out_en_n_a,
  input wire logic       i_out_en_n_b,
  input wire logic [7:0] o_shared_parallel_pins,
  input wire logic [7:0] o_shared_parallel_pins_oe,
  input wire logic       o_serial_out_first,
  input wire logic       o_serial_out_last
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  sequence s_off;
    (i_out_en_n_a || i_out_en_n_b)[*6];
  endsequence
  sequence s_load;
    (i_mode_sel_lo && i_mode_sel_hi)[*6];
  endsequence
  sequence s_on;
    (!i_out_en_n_a && !i_out_en_n_b && !(i_mode_sel_lo && i_mode_sel_hi))[*6];
  endsequence
  sequence s_hold;
    (!i_mode_sel_lo && !i_mode_sel_hi && i_master_clear_n)[*6] ##1 i_master_clear_n;
  endsequence
  sequence s_idle;
    (!i_shift_clock)[*6] ##1 i_master_clear_n;
  endsequence
  AST_OE_OFF: assert property (s_off |=> o_shared_parallel_pins_oe == 8'h00)
    else $error("pins driven while disabled");
  AST_OE_LOAD: assert property (s_load |=> o_shared_parallel_pins_oe == 8'h00)
    else $error("pins driven in load mode");
  AST_OE_ON: assert property (s_on |=> o_shared_parallel_pins_oe == 8'hff)
    else $error("pins not driven");
  AST_OE_EQ: assert property (o_shared_parallel_pins_oe == 8'h00 || o_shared_parallel_pins_oe == 8'hff)
    else $error("pin enables differ");
  AST_SER: assert property (o_serial_out_first == o_shared_parallel_pins[0] &&
    o_serial_out_last == o_shared_parallel_pins[7]) else $error("serial outs differ from state");
  AST_CLR: assert property (!i_master_clear_n |=> o_shared_parallel_pins == 8'h00 && !o_serial_out_last)
    else $error("state not cleared");
  AST_HOLD: assert property (s_hold |-> $stable(o_shared_parallel_pins))
    else $error("state moved in hold");
  AST_IDLE: assert property (s_idle |-> $stable(o_shared_parallel_pins))
    else $error("state moved without clock edge");
endmodule

// ### tb/usr_bus_model.sv
// outside bus logic driving the shared parallel pins
`timescale 1ns/1ps
module usr_bus_model (
  input  wire logic       i_clock,
  input  wire logic       i_drive,
  input  wire logic [7:0] i_word,
  input  wire logic [7:0] i_dev_data,
  input  wire logic [7:0] i_dev_oe,
  output logic      [7:0] o_wire
);
  logic [7:0] last_q = 8'h00;
  always @(posedge i_clock) last_q <= ~last_q;
  // undriven pins toggle every cycle
  assign o_wire = (i_dev_data & i_dev_oe) | ((i_drive ? i_word : last_q) & ~i_dev_oe);
endmodule

// ### tb/usr_top_tb.sv
// self-checking bench for the universal shift register
`timescale 1ns/1ps
module usr_top_tb;
  logic       clk = 1'b0, rst_n = 1'b0, sclk = 1'b0, clr_n = 1'b1, lo = 1'b0, hi = 1'b0, rdy = 1'b1;
  logic       sr = 1'b0, sl = 1'b0, oa_n = 1'b1, ob_n = 1'b1, drive = 1'b0;
  logic [7:0] word = 8'h00, exp_q = 8'h00;
  logic [7:0] pins, dout, oe, sdata;
  logic       sfirst, slast, svalid, slost;
  int         fail_count = 0, checks = 0, cyc = 0;
  always #4 clk = ~clk;
  usr_bus_model usr_bus_model_inst (.i_clock(clk), .i_drive(drive), .i_word(word), .i_dev_data(dout),
    .i_dev_oe(oe), .o_wire(pins));
  usr_top usr_top_inst (.i_clock(clk), .i_rst_n(rst_n), .i_shift_clock(sclk), .i_master_clear_n(clr_n),
    .i_mode_sel_lo(lo), .i_mode_sel_hi(hi), .i_serial_in_right(sr), .i_serial_in_left(sl),
    .i_out_en_n_a(oa_n), .i_out_en_n_b(ob_n), .i_shared_parallel_pins(pins), .o_shared_parallel_pins(dout),
    .o_shared_parallel_pins_oe(oe), .o_serial_out_first(sfirst), .o_serial_out_last(slast),
    .o_snap_valid(svalid), .o_snap_data(sdata), .i_snap_ready(rdy), .o_snap_lost(slost));
  task automatic print_verdict();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      fail_count++;
      print_verdict();
    end
  end
  task automatic cmp8(input logic [7:0] got, input logic [7:0] want);
    checks++;
    if (got !== want) begin
      fail_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic cyc_n(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic pulse(input logic l, input logic h, input logic r, input logic f);
    lo = l;
    hi = h;
    sr = r;
    sl = f;
    cyc_n(3);
    sclk = 1'b1;
    cyc_n(3);
    sclk = 1'b0;
    cyc_n(3);
  endtask
  task automatic chk_state();
    cmp8(dout, exp_q);
    cmp8({6'h00, slast, sfirst}, {6'h00, exp_q[7], exp_q[0]});
  endtask
  task automatic t_load(input logic [7:0] w);
    word = w;
    drive = 1'b1;
    pulse(1'b1, 1'b1, 1'b0, 1'b0);
    cmp8(oe, 8'h00);
    drive = 1'b0;
    exp_q = w;
    chk_state();
  endtask
  task automatic t_shift(input logic left, input logic b);
    pulse(~left, left, b, ~b);
    exp_q = left ? {~b, exp_q[7:1]} : {exp_q[6:0], b};
    chk_state();
  endtask
  task automatic t_oe();
    oa_n = 1'b0;
    ob_n = 1'b0;
    cyc_n(4);
    cmp8(oe, 8'hff);
    cmp8(pins, exp_q);
    t_load(8'h5a);
    pulse(1'b0, 1'b0, 1'b0, 1'b0);
    cmp8(oe, 8'hff);
    cmp8(pins, exp_q);
    ob_n = 1'b1;
    cyc_n(4);
    cmp8(oe, 8'h00);
    t_load(8'h3c);
    t_shift(1'b0, 1'b0);
    ob_n = 1'b0;
  endtask
  task automatic t_hold();
    pulse(1'b0, 1'b0, 1'b1, 1'b1);
    chk_state();
  endtask
  task automatic t_clear();
    clr_n = 1'b0;
    #1;
    cmp8(dout, 8'h00);
    pulse(1'b0, 1'b1, 1'b1, 1'b1);
    clr_n = 1'b1;
    exp_q = 8'h00;
    cyc_n(3);
    chk_state();
  endtask
  task automatic t_snap();
    int n;
    logic [7:0] first;
    n = 0;
    first = 8'h00;
    rdy = 1'b0;
    for (int i = 0; i < 12; i++) begin
      t_shift(1'b1, i[0]);
    end
    cmp8({7'h00, slost}, 8'h01);
    repeat (16) begin
      if (svalid === 1'b1) begin
        if (n == 0) first = sdata;
        n++;
      end
      rdy = 1'b1;
      @(negedge clk);
    end
    cmp8(first, 8'h80);
    cmp8(n[7:0], 8'h0a);
  endtask
  initial begin
    cyc_n(2);
    rst_n = 1'b1;
    cyc_n(4);
    t_load(8'ha5);
    t_shift(1'b0, 1'b1);
    t_shift(1'b1, 1'b0);
    t_hold();
    t_oe();
    t_clear();
    t_snap();
    print_verdict();
  end
endmodule
bind usr_top usr_asserts usr_asserts_inst (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_shift_clock(i_shift_clock),
  .i_master_clear_n(i_master_clear_n), .i_mode_sel_lo(i_mode_sel_lo), .i_mode_sel_hi(i_mode_sel_hi),
  .i_out_en_n_a(i_out_en_n_a), .i_out_en_n_b(i_out_en_n_b), .o_shared_parallel_pins(o_shared_parallel_pins),
  .o_shared_parallel_pins_oe(o_shared_parallel_pins_oe), .o_serial_out_first(o_serial_out_first),
  .o_serial_out_last(o_serial_out_last));
